/* verilog/bip_interlock.sv */
// Bay removal interlock with removal request handshake and the
// read-only power capability table.
// Assumes host pulses are on core_clk; button, theft lock and
// presence pins are asynchronous.
`timescale 1ns/1ps
`include "bip_params.svh"

// Contract
// - Bay interlock holds the device until the host commands release.
// - Button or software press raises a request; lock holds until authorized.
// - Each entry is 32 bits: 8 voltage, 2 type, 22 power.
// - Voltage field counts tenths of a volt, unsigned.
// - Rails coded as 3.3 V, 5.0 V and 12.0 V fixed codes.
// - Power field counts milliwatts, unsigned, 22 bits.
// - Type 00 is continuous power; types 10 and 11 never emitted.
// - Type 01 is absolute peak power, not an increment.
// - At least four entries: three continuous rails plus total.
// - Every supplied voltage has a continuous entry.
// - Peak entry optional; absent peak equals continuous.
// - Total power uses the total/thermal format.
// - Thermal entry only when it differs from total power.
// - Total/thermal entries carry all ones in the top byte.
// - Aggregate entry mandatory; absent thermal equals aggregate.
module bip_interlock #(
    parameter logic [21:0] CONT_3V3_MW = 22'h001770,
    parameter logic [21:0] CONT_5V0_MW = 22'h002710,
    parameter logic [21:0] CONT_12V_MW = 22'h004E20,
    parameter logic [21:0] TOTAL_MW = 22'h0061A8,
    parameter logic [21:0] PEAK_3V3_MW = 22'h000000,
    parameter logic [21:0] PEAK_5V0_MW = 22'h000000,
    parameter logic [21:0] PEAK_12V_MW = 22'h000000,
    parameter logic [21:0] THERM_MW = 22'h000000
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Bay pins
    input wire logic release_button,
    input wire logic theft_lock_pin,
    input wire logic device_present,
    output logic interlock_engaged_q,
    // Host interlock handshake
    input wire logic sw_release_req,
    input wire logic host_auth,
    input wire logic host_deny,
    input wire logic host_relock,
    output logic removal_req_q,
    output logic theft_lock_q,
    // Capability entry reads
    input wire logic cap_rd_req,
    input wire logic [2:0] cap_rd_idx,
    output logic cap_rd_valid_q,
    output logic cap_rd_present_q,
    output bip_pkg::bip_entry_t cap_rd_data_q
);
    import bip_pkg::*;

    // ==========================================================
    // Pin synchronisers
    logic [1:0] btn_s_q;
    logic btn_d1_q;
    logic [1:0] theft_s_q;
    logic [1:0] pres_s_q;
    logic press;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            btn_s_q <= 2'h0;
            btn_d1_q <= 1'b0;
            theft_s_q <= 2'h0;
            pres_s_q <= 2'h0;
        end else begin
            btn_s_q <= {btn_s_q[0], release_button};
            btn_d1_q <= btn_s_q[1];
            theft_s_q <= {theft_s_q[0], theft_lock_pin};
            pres_s_q <= {pres_s_q[0], device_present};
        end
    end

    // Edge taken only from the second stage
    assign press = (btn_s_q[1] & ~btn_d1_q) | sw_release_req;

    // Reported so the host can check before authorizing
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            theft_lock_q <= 1'b0;
        end else begin
            theft_lock_q <= theft_s_q[1];
        end
    end

    // ==========================================================
    // Interlock state
    bip_state_t state_q;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state_q <= BIP_LOCKED;
        end else begin
            case (state_q)
                BIP_LOCKED: begin
                    if (press) begin
                        state_q <= BIP_REQ;
                    end
                end
                BIP_REQ: begin
                    // A fresh press beats a same-cycle deny
                    if (host_auth) begin
                        state_q <= BIP_RELEASED;
                    end else if (host_deny && !press) begin
                        state_q <= BIP_LOCKED;
                    end
                end
                BIP_RELEASED: begin
                    // Device gone or reuse requested: hold next insert
                    if (host_relock || !pres_s_q[1]) begin
                        state_q <= BIP_LOCKED;
                    end
                end
                default: begin
                    state_q <= BIP_LOCKED;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            interlock_engaged_q <= `BIP_RST_ENGAGED;
            removal_req_q <= `BIP_RST_REQ;
        end else begin
            case (state_q)
                BIP_LOCKED: begin
                    interlock_engaged_q <= 1'b1;
                    removal_req_q <= press;
                end
                BIP_REQ: begin
                    interlock_engaged_q <= !host_auth;
                    removal_req_q <= !host_auth && !(host_deny && !press);
                end
                BIP_RELEASED: begin
                    interlock_engaged_q <= host_relock || !pres_s_q[1];
                    removal_req_q <= 1'b0;
                end
                default: begin
                    interlock_engaged_q <= 1'b1;
                    removal_req_q <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // Capability entry reads
    bip_cap_if cap_bus ();

    assign cap_bus.idx = cap_rd_idx;

    bip_cap_table #(
        .CONT_3V3_MW(CONT_3V3_MW),
        .CONT_5V0_MW(CONT_5V0_MW),
        .CONT_12V_MW(CONT_12V_MW),
        .TOTAL_MW(TOTAL_MW),
        .PEAK_3V3_MW(PEAK_3V3_MW),
        .PEAK_5V0_MW(PEAK_5V0_MW),
        .PEAK_12V_MW(PEAK_12V_MW),
        .THERM_MW(THERM_MW)
    ) u_table (
        .cap(cap_bus.table_side)
    );

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            cap_rd_valid_q <= 1'b0;
            cap_rd_present_q <= 1'b0;
            cap_rd_data_q <= `BIP_RST_DATA;
        end else begin
            cap_rd_valid_q <= cap_rd_req;
            if (cap_rd_req) begin
                cap_rd_present_q <= cap_bus.present;
                cap_rd_data_q <= cap_bus.entry;
            end
        end
    end

    // ==========================================================
    // Checks
    chk_lock_after_reset: assert property (
        @(posedge core_clk) $rose(nrst) |-> interlock_engaged_q
            && !removal_req_q)
        else $error("interlock not engaged after reset");

    chk_release_needs_auth: assert property (
        @(posedge core_clk) disable iff (!nrst)
        $fell(interlock_engaged_q) |-> $past(host_auth)
            && $past(state_q) == BIP_REQ)
        else $error("interlock released without authorization");

    chk_press_raises_req: assert property (
        @(posedge core_clk) disable iff (!nrst)
        state_q == BIP_LOCKED && sw_release_req |=>
            removal_req_q && interlock_engaged_q)
        else $error("press did not raise removal request");

    chk_req_holds_lock: assert property (
        @(posedge core_clk) disable iff (!nrst)
        removal_req_q |-> interlock_engaged_q)
        else $error("lock open while request pending");

    chk_read_answer: assert property (
        @(posedge core_clk) disable iff (!nrst)
        cap_rd_req |=> cap_rd_valid_q ##0
            cap_rd_data_q == $past(cap_bus.entry))
        else $error("entry read answer wrong or late");

    chk_no_reserved_type: assert property (
        @(posedge core_clk) disable iff (!nrst)
        cap_rd_valid_q |-> cap_rd_data_q.ptype[1] == 1'b0)
        else $error("reserved power type emitted");

    chk_min_entries: assert property (
        @(posedge core_clk) disable iff (!nrst)
        cap_rd_req && cap_rd_idx < `BIP_MIN_SLOTS |=> cap_rd_present_q)
        else $error("mandatory entry missing");

    chk_volt_codes: assert property (
        @(posedge core_clk) disable iff (!nrst)
        cap_rd_req && cap_rd_idx == `BIP_SLOT_CONT_12V |=>
            cap_rd_data_q.volt == `BIP_VOLT_12V)
        else $error("wrong 12 V rail code");

    chk_total_format: assert property (
        @(posedge core_clk) disable iff (!nrst)
        cap_rd_req && cap_rd_idx == `BIP_SLOT_TOTAL |=>
            cap_rd_data_q.volt == `BIP_VOLT_TOTAL
            && cap_rd_data_q.ptype == `BIP_TYPE_AGGR)
        else $error("total entry format wrong");

    cov_full_release: cover property (
        @(posedge core_clk) disable iff (!nrst)
        removal_req_q ##1 !interlock_engaged_q);

    cov_denied: cover property (
        @(posedge core_clk) disable iff (!nrst)
        state_q == BIP_REQ && host_deny ##1 state_q == BIP_LOCKED);

    cov_removed: cover property (
        @(posedge core_clk) disable iff (!nrst)
        !interlock_engaged_q ##1 interlock_engaged_q);

    cov_absent_read: cover property (
        @(posedge core_clk) disable iff (!nrst)
        cap_rd_valid_q && !cap_rd_present_q);
endmodule : bip_interlock

/* verilog/bip_params.svh */
// Constants for the bay interlock and power capability block.
// Assumes inclusion by bare name from the interlock and capability table modules.
`ifndef BIP_PARAMS_SVH
`define BIP_PARAMS_SVH

// ==========================================================
// Entry field positions
`define BIP_VOLT_MSB 31
`define BIP_VOLT_LSB 24
`define BIP_TYPE_MSB 23
`define BIP_TYPE_LSB 22
`define BIP_MW_MSB 21
`define BIP_MW_LSB 0

// ==========================================================
// Field codes
`define BIP_VOLT_3V3 8'h21
`define BIP_VOLT_5V0 8'h32
`define BIP_VOLT_12V 8'h78
`define BIP_VOLT_TOTAL 8'hFF
`define BIP_TYPE_CONT 2'h0
`define BIP_TYPE_PEAK 2'h1
`define BIP_TYPE_THERM 2'h0
`define BIP_TYPE_AGGR 2'h1

// ==========================================================
// Entry slot indexes
`define BIP_SLOT_CONT_3V3 3'h0
`define BIP_SLOT_CONT_5V0 3'h1
`define BIP_SLOT_CONT_12V 3'h2
`define BIP_SLOT_TOTAL 3'h3
`define BIP_SLOT_PEAK_3V3 3'h4
`define BIP_SLOT_PEAK_5V0 3'h5
`define BIP_SLOT_PEAK_12V 3'h6
`define BIP_SLOT_THERM 3'h7
`define BIP_MIN_SLOTS 3'h4

// ==========================================================
// Reset values
`define BIP_RST_ENGAGED 1'b1
`define BIP_RST_REQ 1'b0
`define BIP_RST_DATA 32'h00000000

`endif

/* verilog/bip_pkg.sv */
// Types for the bay interlock and power capability block.
// Assumes bip_params.svh is on the include path.
package bip_pkg;
    // Gray along locked -> requested -> released
    typedef enum logic [1:0] {
        BIP_LOCKED = 2'h0,
        BIP_REQ = 2'h1,
        BIP_RELEASED = 2'h3
    } bip_state_t;

    typedef struct packed {
        logic [7:0] volt;
        logic [1:0] ptype;
        logic [21:0] mw;
    } bip_entry_t;
endpackage : bip_pkg

/* verilog/bip_cap_if.sv */
// Interface between the interlock top and the capability table.
// Assumes bip_pkg is compiled first.
`timescale 1ns/1ps
interface bip_cap_if;
    import bip_pkg::*;
    logic [2:0] idx;
    bip_entry_t entry;
    logic present;
    modport table_side (input idx, output entry, output present);
    modport reader (output idx, input entry, input present);
endinterface : bip_cap_if

/* verilog/bip_cap_table.sv */
// Constant table of power capability entries, selected by slot index.
// Assumes the reader registers the answer; this module is combinational.
`timescale 1ns/1ps
`include "bip_params.svh"
module bip_cap_table #(
    parameter logic [21:0] CONT_3V3_MW = 22'h001770,
    parameter logic [21:0] CONT_5V0_MW = 22'h002710,
    parameter logic [21:0] CONT_12V_MW = 22'h004E20,
    parameter logic [21:0] TOTAL_MW = 22'h0061A8,
    // Zero means no peak entry: peak equals continuous
    parameter logic [21:0] PEAK_3V3_MW = 22'h000000,
    parameter logic [21:0] PEAK_5V0_MW = 22'h000000,
    parameter logic [21:0] PEAK_12V_MW = 22'h000000,
    // Zero means thermal equals total
    parameter logic [21:0] THERM_MW = 22'h000000
) (
    bip_cap_if.table_side cap
);
    import bip_pkg::*;

    function automatic bip_entry_t mk(input logic [7:0] v,
                                      input logic [1:0] t,
                                      input logic [21:0] mw);
        bip_entry_t e;
        e.volt = v;
        e.ptype = t;
        e.mw = mw;
        return e;
    endfunction : mk

    // ==========================================================
    // Slot decode
    always_comb begin
        cap.present = 1'b1;
        case (cap.idx)
            `BIP_SLOT_CONT_3V3:
                cap.entry = mk(`BIP_VOLT_3V3, `BIP_TYPE_CONT,
                               CONT_3V3_MW);
            `BIP_SLOT_CONT_5V0:
                cap.entry = mk(`BIP_VOLT_5V0, `BIP_TYPE_CONT,
                               CONT_5V0_MW);
            `BIP_SLOT_CONT_12V:
                cap.entry = mk(`BIP_VOLT_12V, `BIP_TYPE_CONT,
                               CONT_12V_MW);
            `BIP_SLOT_TOTAL:
                cap.entry = mk(`BIP_VOLT_TOTAL, `BIP_TYPE_AGGR,
                               TOTAL_MW);
            `BIP_SLOT_PEAK_3V3: begin
                cap.entry = mk(`BIP_VOLT_3V3, `BIP_TYPE_PEAK,
                               PEAK_3V3_MW);
                cap.present = (PEAK_3V3_MW != 22'h000000);
            end
            `BIP_SLOT_PEAK_5V0: begin
                cap.entry = mk(`BIP_VOLT_5V0, `BIP_TYPE_PEAK,
                               PEAK_5V0_MW);
                cap.present = (PEAK_5V0_MW != 22'h000000);
            end
            `BIP_SLOT_PEAK_12V: begin
                cap.entry = mk(`BIP_VOLT_12V, `BIP_TYPE_PEAK,
                               PEAK_12V_MW);
                cap.present = (PEAK_12V_MW != 22'h000000);
            end
            default: begin
                cap.entry = mk(`BIP_VOLT_TOTAL, `BIP_TYPE_THERM,
                               THERM_MW);
                // Only offered when it differs from the total
                cap.present = (THERM_MW != 22'h000000) &&
                              (THERM_MW != TOTAL_MW);
            end
        endcase
        if (!cap.present) begin
            cap.entry = mk(8'h00, 2'h0, 22'h000000);
        end
    end
endmodule : bip_cap_table

/* sim/bip_host_model.sv */
// Host software stand-in that answers removal requests on the interlock.
// Assumes it shares core_clk and nrst with the interlock block.
`timescale 1ns/1ps
module bip_host_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Device status
    input wire logic removal_req_q,
    input wire logic theft_lock_q,
    // Bench controls
    input wire logic [2:0] wait_cycles,
    input wire logic relock_now,
    input wire logic stray_auth,
    // Host pulses
    output logic host_auth,
    output logic host_deny,
    output logic host_relock
);
    logic [2:0] cnt_q;

    // ==========================================================
    // Request answer
    // Stray pulses exist only so a scenario can probe an authorization without a request
    always_ff @(posedge core_clk) begin
        host_auth <= stray_auth;
        host_deny <= 1'b0;
        host_relock <= relock_now;
        if (!nrst || !removal_req_q || host_auth || host_deny) begin
            cnt_q <= 3'h0;
        end else if (cnt_q == wait_cycles) begin
            cnt_q <= 3'h0;
            // Shared mechanism: never release over an engaged theft lock
            host_auth <= !theft_lock_q;
            host_deny <= theft_lock_q;
        end else begin
            cnt_q <= cnt_q + 3'h1;
        end
    end
endmodule : bip_host_model

/* sim/bay_interlock_power_capability_tb.sv */
// Self-checking bench for the interlock and capability table.
// Assumes the host model answers every removal request.
`timescale 1ns/1ps
module bay_interlock_power_capability_tb;
    import bip_pkg::*;
    localparam logic [21:0] C3 = 22'h000BB8;
    localparam logic [21:0] C5 = 22'h002710;
    localparam logic [21:0] C12 = 22'h004E20;
    localparam logic [21:0] TOT = 22'h0061A8;
    localparam logic [21:0] P5 = 22'h003A98;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic release_button = 1'b0;
    logic theft_lock_pin = 1'b0;
    logic device_present = 1'b1;
    logic sw_release_req = 1'b0;
    logic cap_rd_req = 1'b0;
    logic [2:0] cap_rd_idx = 3'h0;
    logic [2:0] wait_cycles = 3'h0;
    logic relock_now = 1'b0;
    logic stray_auth = 1'b0;
    logic host_auth, host_deny, host_relock;
    logic interlock_engaged_q, removal_req_q, theft_lock_q;
    logic cap_rd_valid_q, cap_rd_present_q;
    bip_entry_t cap_rd_data_q;
    logic [31:0] lfsr = 32'h105FBA44;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;

    always #2.5 core_clk = ~core_clk;

    bip_interlock #(.CONT_3V3_MW(C3), .CONT_5V0_MW(C5), .CONT_12V_MW(C12),
        .TOTAL_MW(TOT), .PEAK_5V0_MW(P5), .THERM_MW(TOT)) DUT (
        .core_clk(core_clk), .nrst(nrst), .release_button(release_button),
        .theft_lock_pin(theft_lock_pin), .device_present(device_present),
        .interlock_engaged_q(interlock_engaged_q),
        .sw_release_req(sw_release_req), .host_auth(host_auth),
        .host_deny(host_deny), .host_relock(host_relock),
        .removal_req_q(removal_req_q), .theft_lock_q(theft_lock_q),
        .cap_rd_req(cap_rd_req), .cap_rd_idx(cap_rd_idx),
        .cap_rd_valid_q(cap_rd_valid_q), .cap_rd_present_q(cap_rd_present_q),
        .cap_rd_data_q(cap_rd_data_q));

    bip_host_model host (.core_clk(core_clk), .nrst(nrst),
        .removal_req_q(removal_req_q), .theft_lock_q(theft_lock_q),
        .wait_cycles(wait_cycles), .relock_now(relock_now),
        .stray_auth(stray_auth), .host_auth(host_auth),
        .host_deny(host_deny), .host_relock(host_relock));

    // ==========================================================
    // Helpers
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next

    // Returns {present, entry}; absent slots read as zero
    function automatic logic [32:0] exp_ent(input logic [2:0] i);
        case (i)
            3'h0: exp_ent = {1'b1, 8'h21, 2'h0, C3};
            3'h1: exp_ent = {1'b1, 8'h32, 2'h0, C5};
            3'h2: exp_ent = {1'b1, 8'h78, 2'h0, C12};
            3'h3: exp_ent = {1'b1, 8'hFF, 2'h1, TOT};
            3'h5: exp_ent = {1'b1, 8'h32, 2'h1, P5};
            default: exp_ent = 33'h0;
        endcase
    endfunction : exp_ent

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Polls engaged (sel 0) or request (sel 1) for a level, bounded
    task automatic wait_lvl(input bit sel, input logic lvl, input int lim);
        int n;
        n = 0;
        while ((sel ? removal_req_q : interlock_engaged_q) !== lvl
               && n < lim) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk(sel ? removal_req_q : interlock_engaged_q, lvl);
    endtask : wait_lvl

    task automatic sw_press;
        @(posedge core_clk);
        sw_release_req <= 1'b1;
        @(posedge core_clk);
        sw_release_req <= 1'b0;
        #1;
        chk(removal_req_q, 1'b1);
        chk(interlock_engaged_q, 1'b1);
    endtask : sw_press

    task automatic final_report;
        $display("compares=%0d mismatches=%0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            final_report();
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        logic [32:0] last;
        logic pv;
        logic [2:0] pidx;
        repeat (5) @(posedge core_clk);
        nrst <= 1'b1;
        #1;
        chk({interlock_engaged_q, removal_req_q, cap_rd_valid_q}, 3'h4);
        chk({cap_rd_present_q, cap_rd_data_q}, 33'h0);
        $display("test reset done");
        // Back-to-back and random table reads
        pv = 1'b0;
        pidx = 3'h0;
        last = 33'h0;
        for (int k = 0; k < 60; k++) begin
            @(posedge core_clk);
            lfsr = lfsr_next(lfsr);
            cap_rd_req <= (k < 8) || lfsr[0];
            cap_rd_idx <= (k < 8) ? k[2:0] : lfsr[3:1];
            #1;
            chk(cap_rd_valid_q, pv);
            if (pv) begin
                last = exp_ent(pidx);
                chk(cap_rd_data_q[23], 1'b0);
            end
            chk({cap_rd_present_q, cap_rd_data_q}, last);
            pv = cap_rd_req;
            pidx = cap_rd_idx;
        end
        @(posedge core_clk);
        cap_rd_req <= 1'b0;
        #1;
        chk(cap_rd_valid_q, pv);
        $display("test table done");
        // Software press with prompt and slow host answers
        repeat (4) begin
            lfsr = lfsr_next(lfsr);
            wait_cycles <= lfsr[2:0];
            sw_press();
            wait_lvl(1'b0, 1'b0, 12);
            chk(removal_req_q, 1'b0);
            @(posedge core_clk);
            device_present <= 1'b0;
            wait_lvl(1'b0, 1'b1, 6);
            @(posedge core_clk);
            device_present <= 1'b1;
            repeat (3) @(posedge core_clk);
        end
        $display("test release done");
        // Theft lock engaged: host refuses, interlock holds
        theft_lock_pin <= 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        chk(theft_lock_q, 1'b1);
        sw_press();
        wait_lvl(1'b1, 1'b0, 12);
        repeat (2) @(posedge core_clk);
        #1;
        chk(interlock_engaged_q, 1'b1);
        @(posedge core_clk);
        theft_lock_pin <= 1'b0;
        $display("test deny done");
        // Button press then host re-lock for reuse
        repeat (4) @(posedge core_clk);
        release_button <= 1'b1;
        wait_lvl(1'b1, 1'b1, 5);
        wait_lvl(1'b0, 1'b0, 12);
        @(posedge core_clk);
        release_button <= 1'b0;
        @(posedge core_clk);
        relock_now <= 1'b1;
        @(posedge core_clk);
        relock_now <= 1'b0;
        wait_lvl(1'b0, 1'b1, 2);
        $display("test relock done");
        // Authorization without a request is ignored
        @(posedge core_clk);
        stray_auth <= 1'b1;
        @(posedge core_clk);
        stray_auth <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        chk({interlock_engaged_q, removal_req_q}, 2'h2);
        $display("test stray done");
        final_report();
    end
endmodule : bay_interlock_power_capability_tb
